// ---- hw/osf_params.svh ----
// Overview of operation
// R1: code 000 none, 001-110 ratio 2-64, 111 invalid
// R2: code 000 passes each conversion straight through
// R3: burst rate falls with ratio; host respects it
// R4: first burst sample on convert-start rising edge
// R5: later samples from internal sampling pulse
// R6: all burst samples of a channel are averaged
// R7: one 16-bit word per channel per burst
// R8: range pin sets front-end gain for all channels
// R9: reference source follows only the select pin
// R10: reference buffer stays enabled in both modes
// R11: high selects internal reference, low powers it down
// R12: mean is signed sum divided by ratio
`ifndef OSF_PARAMS_SVH
`define OSF_PARAMS_SVH

// ***************************************************************
// sizes
// ***************************************************************
`define OSF_NUM_CH 4
`define OSF_SAMPLE_W 16
`define OSF_ACC_W 22
`define OSF_PIN_W 7

// ***************************************************************
// timing: fastest per-channel rate against the pclk rate
// ***************************************************************
`define OSF_CLK_KHZ 25000
`define OSF_MAX_RATE_KSPS 330
`define OSF_SAMPLE_CYCLES ((`OSF_CLK_KHZ + `OSF_MAX_RATE_KSPS - 1) / `OSF_MAX_RATE_KSPS)
`define OSF_CNT_W 8

// ***************************************************************
// ratio codes
// ***************************************************************
`define OSF_OS_NONE 3'h0
`define OSF_OS_INVALID 3'h7

// ***************************************************************
// register map (byte addresses)
// ***************************************************************
`define OSF_ADDR_W 12
`define OSF_CTRL_OFS 12'h000
`define OSF_STATUS_OFS 12'h004
`define OSF_BURSTS_OFS 12'h008
`define OSF_DATA_BASE 12'h010
`define OSF_CTRL_RST 1'h1
`define OSF_CTRL_EN_BIT 0
`define OSF_ST_BUSY_BIT 0
`define OSF_ST_INVALID_BIT 1
`define OSF_ST_CODE_LSB 2
`define OSF_ST_RANGE_BIT 5
`define OSF_ST_REFERENCE_SOURCE_SELECT_BIT 6
`define OSF_ST_VALID_BIT 7

`endif

// ---- hw/osf_pkg.sv ----
package osf_pkg;
	typedef enum logic [1:0] {
		OSF_IDLE,
		OSF_CONVERT,
		OSF_WAIT,
		OSF_GAP
	} osf_state_e;

	// one simultaneous conversion result, channel 0 in the low word
	typedef struct packed {
		logic [3:0][15:0] ch;
	} osf_sample_s;

	// apb request from the master
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} osf_apb_req_s;
endpackage : osf_pkg

// ---- hw/osf_avg_lane.sv ----
`timescale 1ns/1ps
`include "osf_params.svh"

// one channel: signed accumulate, then divide by the ratio
module osf_avg_lane (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clear,
	input wire logic add,
	input wire logic last,
	input wire logic [2:0] shift,
	input wire logic [15:0] sample,
	output logic [15:0] mean_r
);
	logic signed [21:0] acc_r;
	logic signed [21:0] sum_nxt;
	logic signed [21:0] mean_nxt;

	// running sum including the incoming sample
	assign sum_nxt = acc_r + {{6{sample[15]}}, sample}; // R6
	// power-of-two ratio, arithmetic shift keeps twos complement
	assign mean_nxt = sum_nxt >>> shift; // R12

	// ***************************************************************
	// accumulator
	// ***************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			acc_r <= 22'h000000;
		end else if (clear) begin
			acc_r <= 22'h000000;
		end else if (add) begin
			acc_r <= sum_nxt;
		end
	end

	// one decimated word per burst; shift 0 passes the sample through
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mean_r <= 16'h0000;
		end else if (add && last) begin
			mean_r <= mean_nxt[15:0]; // R7 R2
		end
	end
endmodule : osf_avg_lane

// ---- hw/osf_filter.sv ----
`timescale 1ns/1ps
`include "osf_params.svh"

// oversampling and averaging filter with apb status and results
module osf_filter #(
	parameter int NUM_CH = `OSF_NUM_CH,
	parameter logic [7:0] SAMPLE_CYCLES = 8'(`OSF_SAMPLE_CYCLES)
) (
	input wire logic pclk,
	input wire logic presetn,
	input osf_pkg::osf_apb_req_s apb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [2:0] oversample_ratio_select,
	input wire logic convert_start_group_a,
	input wire logic convert_start_group_b,
	input wire logic range_select,
	input wire logic reference_source_select,
	input wire logic adc_done,
	input osf_pkg::osf_sample_s adc_sample,
	output logic adc_convert,
	output logic busy,
	output logic result_valid,
	output logic pga_range_wide,
	output logic internal_ref_enable,
	output logic reference_io_pin_oe,
	output logic ref_buffer_enable
);
	// ***************************************************************
	// pin synchronisers
	// ***************************************************************
	logic [6:0] pin_meta_r;
	logic [6:0] pin_sync_r;
	logic start_both_prev_r;
	logic [6:0] pin_raw;
	logic [2:0] os_code;
	logic start_both;
	logic start_edge;
	logic range_pin;
	logic reference_source_select_pin;

	// all seven pin bits in one vector, ratio code in the top three
	assign pin_raw = {oversample_ratio_select, convert_start_group_a,
		convert_start_group_b, range_select, reference_source_select};

	// two flops before any logic looks at a pin; the previous start level is
	// kept so that a held convert-start does not open a second burst
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_meta_r <= 7'h00;
			pin_sync_r <= 7'h00;
			start_both_prev_r <= 1'b0;
		end else begin
			pin_meta_r <= pin_raw;
			pin_sync_r <= pin_meta_r;
			start_both_prev_r <= start_both;
		end
	end

	// decoded pin levels; a burst opens only once both start groups are high,
	// so a skew between the two pins cannot split one request into two
	assign os_code = pin_sync_r[6:4];
	assign start_both = pin_sync_r[3] & pin_sync_r[2];
	assign start_edge = start_both & ~start_both_prev_r; // R4
	assign range_pin = pin_sync_r[1];
	assign reference_source_select_pin = pin_sync_r[0];

	// ***************************************************************
	// ratio decode
	// ***************************************************************
	logic code_invalid;
	logic [6:0] code_ratio;

	// code n gives ratio 2^n, shift n; 111 is refused
	// the divide is then a plain arithmetic shift in every lane
	assign code_invalid = (os_code == `OSF_OS_INVALID); // R1
	assign code_ratio = 7'h01 << os_code; // R1

	// ***************************************************************
	// burst sequencer
	// ***************************************************************
	osf_pkg::osf_state_e state_r;
	osf_pkg::osf_state_e state_nxt;
	logic [2:0] shift_r;
	logic [6:0] ratio_r;
	logic [6:0] taken_r;
	logic [7:0] period_r;
	logic ctrl_en_r;
	logic accept;
	logic sample_add;
	logic sample_last;
	logic period_done;
	logic burst_done;

	assign period_done = (period_r == 8'h00);
	// a new burst only when idle, enabled, valid code and rate slot free;
	// edges that arrive while a burst runs or too soon after the last
	// conversion are dropped rather than queued
	assign accept = (state_r == osf_pkg::OSF_IDLE) && start_edge && ctrl_en_r
		&& !code_invalid && period_done; // R3 R4
	assign sample_add = (state_r == osf_pkg::OSF_WAIT) && adc_done; // R6
	assign sample_last = (taken_r + 7'h01 == ratio_r); // R7
	assign burst_done = sample_add && sample_last; // R7

	// next state
	// idle -> convert -> wait for the core -> gap -> convert ... -> idle
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			osf_pkg::OSF_IDLE: begin
				if (accept) begin
					state_nxt = osf_pkg::OSF_CONVERT;
				end
			end
			osf_pkg::OSF_CONVERT: begin
				state_nxt = osf_pkg::OSF_WAIT;
			end
			osf_pkg::OSF_WAIT: begin
				if (adc_done) begin
					state_nxt = sample_last ? osf_pkg::OSF_IDLE : osf_pkg::OSF_GAP;
				end
			end
			osf_pkg::OSF_GAP: begin
				// internal sampling pulse, no external edge needed
				if (period_done) begin
					state_nxt = osf_pkg::OSF_CONVERT; // R5
				end
			end
			default: begin
				state_nxt = osf_pkg::OSF_IDLE;
			end
		endcase
	end

	// state, ratio latch and sample count
	// the code is latched at burst start so a pin change mid-burst is harmless
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r <= osf_pkg::OSF_IDLE;
			shift_r <= 3'h0;
			ratio_r <= 7'h01;
			taken_r <= 7'h00;
		end else begin
			state_r <= state_nxt;
			if (accept) begin
				shift_r <= os_code; // R1
				ratio_r <= code_ratio;
				taken_r <= 7'h00;
			end else if (sample_add) begin
				taken_r <= taken_r + 7'h01;
			end
		end
	end

	// sample period timer, restarted at every conversion;
	// conversions are therefore at least SAMPLE_CYCLES + 1 cycles apart,
	// which keeps the per-channel rate at or below the fastest allowed one
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			period_r <= 8'h00;
		end else if (state_r == osf_pkg::OSF_CONVERT) begin
			period_r <= SAMPLE_CYCLES - 8'h01; // R3
		end else if (!period_done) begin
			period_r <= period_r - 8'h01;
		end
	end

	// ***************************************************************
	// per-channel averaging lanes
	// ***************************************************************
	logic [NUM_CH-1:0][15:0] mean;

	// every lane sees the same strobes; only the channel word differs
	generate
		for (genvar i = 0; i < NUM_CH; i++) begin : g_lane
			osf_avg_lane u_lane (
				.pclk(pclk),
				.presetn(presetn),
				.clear(accept),
				.add(sample_add),
				.last(sample_last),
				.shift(shift_r),
				.sample(adc_sample.ch[i]),
				.mean_r(mean[i])
			);
		end
	endgenerate

	// ***************************************************************
	// pin-steered front end and reference
	// ***************************************************************
	// conversion request, burst status and front-end controls;
	// the reference buffer has no off state; the internal reference and the
	// drive of the reference pin follow the synced select level only
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			adc_convert <= 1'b0;
			busy <= 1'b0;
			result_valid <= 1'b0;
			pga_range_wide <= 1'b0;
			internal_ref_enable <= 1'b0;
			reference_io_pin_oe <= 1'b0;
			ref_buffer_enable <= 1'b1;
		end else begin
			adc_convert <= (state_nxt == osf_pkg::OSF_CONVERT);
			busy <= (state_nxt != osf_pkg::OSF_IDLE);
			result_valid <= burst_done; // R7
			pga_range_wide <= range_pin; // R8
			internal_ref_enable <= reference_source_select_pin; // R9 R11
			reference_io_pin_oe <= reference_source_select_pin; // R11
			ref_buffer_enable <= 1'b1; // R10
		end
	end

	// ***************************************************************
	// apb slave
	// ***************************************************************
	logic [15:0] bursts_r;
	logic valid_r;
	logic access;
	logic commit;
	logic hit_ctrl;
	logic hit_status;
	logic hit_bursts;
	logic hit_data;
	logic mapped;
	logic [31:0] status_word;
	logic [31:0] rd_data;
	logic [1:0] data_index;
	logic read_now;

	// first access cycle reads; the pready edge commits writes
	// the read word is captured one cycle ahead so that it stands with pready
	assign access = apb.psel && apb.penable && !pready;
	assign commit = apb.psel && apb.penable && pready;
	assign hit_ctrl = (apb.paddr == `OSF_CTRL_OFS);
	assign hit_status = (apb.paddr == `OSF_STATUS_OFS);
	assign hit_bursts = (apb.paddr == `OSF_BURSTS_OFS);
	assign hit_data = (apb.paddr[11:4] == 8'(`OSF_DATA_BASE >> 4))
		&& (apb.paddr[1:0] == 2'h0);
	assign mapped = hit_ctrl || hit_status || hit_bursts || hit_data;

	// word index within the result block, and a read in its first access cycle
	assign data_index = apb.paddr[3:2];
	assign read_now = access && !apb.pwrite;

	// live status of the block, packed field by field from the bit map
	always_comb begin
		status_word = 32'h00000000;
		status_word[`OSF_ST_BUSY_BIT] = busy;
		status_word[`OSF_ST_INVALID_BIT] = code_invalid;
		status_word[`OSF_ST_CODE_LSB +: 3] = os_code;
		status_word[`OSF_ST_RANGE_BIT] = range_pin;
		status_word[`OSF_ST_REFERENCE_SOURCE_SELECT_BIT] = reference_source_select_pin;
		status_word[`OSF_ST_VALID_BIT] = valid_r;
	end

	// read selection
	assign rd_data = hit_ctrl ? {31'h00000000, ctrl_en_r}
		: hit_status ? status_word
		: hit_bursts ? {16'h0000, bursts_r}
		: hit_data ? {16'h0000, mean[data_index]}
		: 32'h00000000;

	// one wait state, error on unmapped addresses
	// writes to read-only words are accepted and ignored without an error
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end else begin
			pready <= access;
			pslverr <= access && !mapped;
			prdata <= read_now ? rd_data : 32'h00000000;
		end
	end

	// control write; enable gates acceptance of bursts
	// disabling stops new bursts but lets a running one finish
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_en_r <= `OSF_CTRL_RST;
		end else if (commit && apb.pwrite && hit_ctrl) begin
			ctrl_en_r <= apb.pwdata[`OSF_CTRL_EN_BIT];
		end
	end

	// burst counter and sticky result flag; a new result beats the clear
	// the counter wraps silently after 65535 bursts
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bursts_r <= 16'h0000;
			valid_r <= 1'b0;
		end else begin
			if (burst_done) begin
				bursts_r <= bursts_r + 16'h0001;
				valid_r <= 1'b1;
			end else if (commit && !apb.pwrite && hit_data) begin
				valid_r <= 1'b0;
			end
		end
	end
endmodule : osf_filter

// ---- sim/osf_filter_props.sv ----
`timescale 1ns/1ps
// ****
// filter checker
// ****
module osf_filter_props #(
	parameter logic [7:0] SAMPLE_CYCLES = 8'h4C
) (
	input wire logic pclk,
	input wire logic presetn,
	input osf_pkg::osf_apb_req_s apb,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic range_select,
	input wire logic reference_source_select,
	input wire logic adc_done,
	input wire logic adc_convert,
	input wire logic busy,
	input wire logic result_valid,
	input wire logic pga_range_wide,
	input wire logic internal_ref_enable,
	input wire logic reference_io_pin_oe,
	input wire logic ref_buffer_enable
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// pins, apb and burst sequencing
	property p_buf; ref_buffer_enable; endproperty
	a_buf: assert property (p_buf) else $error("ref buffer off");
	property p_oe; internal_ref_enable == reference_io_pin_oe; endproperty
	a_oe: assert property (p_oe) else $error("ref pin drive mismatch");
	property p_ref; $stable(reference_source_select)[*5] |-> internal_ref_enable == reference_source_select; endproperty
	a_ref: assert property (p_ref) else $error("ref select not followed");
	property p_rng; $stable(range_select)[*5] |-> pga_range_wide == range_select; endproperty
	a_rng: assert property (p_rng) else $error("range not followed");
	property p_ans; apb.psel && apb.penable && !pready |=> pready; endproperty
	a_ans: assert property (p_ans) else $error("apb answer late");
	property p_err; pslverr |-> pready && prdata == 32'h0; endproperty
	a_err: assert property (p_err) else $error("bad error answer");
	property p_first; $rose(busy) |-> adc_convert; endproperty
	a_first: assert property (p_first) else $error("burst without conversion");
	property p_inside; adc_convert |-> busy; endproperty
	a_inside: assert property (p_inside) else $error("conversion outside burst");
	property p_gap; adc_convert |=> !adc_convert[*3]; endproperty
	a_gap: assert property (p_gap) else $error("conversions too close");
	property p_end; result_valid |-> !busy && $past(adc_done); endproperty
	a_end: assert property (p_end) else $error("result not after last sample");
	logic [7:0] since_r;
	// cycles since the last conversion request, saturating
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			since_r <= 8'hFF;
		end else if (adc_convert) begin
			since_r <= 8'h01;
		end else if (since_r != 8'hFF) begin
			since_r <= since_r + 8'h01;
		end
	end
	property p_rate; adc_convert |-> since_r >= SAMPLE_CYCLES; endproperty
	a_rate: assert property (p_rate) else $error("sample rate above limit");
	property p_pulse; result_valid |=> !result_valid; endproperty
	a_pulse: assert property (p_pulse) else $error("result flag held");
endmodule : osf_filter_props

bind osf_filter osf_filter_props #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) i_osf_filter_props (
	.pclk(pclk), .presetn(presetn), .apb(apb), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .range_select(range_select),
	.reference_source_select(reference_source_select), .adc_done(adc_done),
	.adc_convert(adc_convert), .busy(busy), .result_valid(result_valid),
	.pga_range_wide(pga_range_wide), .internal_ref_enable(internal_ref_enable),
	.reference_io_pin_oe(reference_io_pin_oe), .ref_buffer_enable(ref_buffer_enable));

// ---- sim/osf_conv_model.sv ----
`timescale 1ns/1ps
// ****
// converter core model
// ****
module osf_conv_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic adc_convert,
	input wire logic [3:0] lag,
	output logic adc_done,
	output osf_pkg::osf_sample_s adc_sample
);
	logic pend_r;
	logic [3:0] wait_r;
	logic [15:0] k_r;
	// answer each conversion lag + 2 cycles after the request; data toggles when not valid
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pend_r <= 1'b0;
			wait_r <= 4'h0;
			k_r <= 16'h0;
			adc_done <= 1'b0;
			adc_sample <= '0;
		end else begin
			adc_done <= 1'b0;
			if (adc_convert) begin
				pend_r <= 1'b1;
				wait_r <= lag;
				adc_sample <= ~adc_sample;
			end else if (pend_r && wait_r != 4'h0) begin
				wait_r <= wait_r - 4'h1;
				adc_sample <= ~adc_sample;
			end else if (pend_r) begin
				pend_r <= 1'b0;
				adc_done <= 1'b1;
				k_r <= k_r + 16'h1;
				for (int i = 0; i < 4; i++) adc_sample.ch[i] <= 16'(16'hF000 + i * 256 + 3 * k_r);
			end else begin
				adc_sample <= ~adc_sample;
			end
		end
	end
endmodule : osf_conv_model

// ---- sim/osf_filter_tb_top.sv ----
`timescale 1ns/1ps
// ****
// filter testbench
// ****
module osf_filter_tb_top;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	osf_pkg::osf_apb_req_s apb = '0;
	logic [31:0] prdata;
	logic pready, pslverr, adc_done, adc_convert, busy, result_valid;
	logic pga_range_wide, internal_ref_enable, reference_io_pin_oe, ref_buffer_enable;
	logic [2:0] osr = 3'h0;
	logic cst_a = 1'b0;
	logic cst_b = 1'b0;
	logic rng = 1'b0;
	logic rsel = 1'b1;
	logic [3:0] lag = 4'h0;
	osf_pkg::osf_sample_s adc_sample;
	logic [31:0] rd;
	logic er;
	int n_mismatch = 0;
	int samples_checked = 0;
	int ncv = 0;
	int k0 = 0;
	int nrv = 0;
	always #20 pclk = ~pclk;
	// count conversion requests
	always @(posedge pclk) if (adc_convert === 1'b1) ncv++;
	// count result pulses
	always @(posedge pclk) if (result_valid === 1'b1) nrv++;
	osf_filter #(.SAMPLE_CYCLES(8'h04)) i_osf_filter (.pclk(pclk), .presetn(presetn), .apb(apb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .oversample_ratio_select(osr),
		.convert_start_group_a(cst_a), .convert_start_group_b(cst_b), .range_select(rng),
		.reference_source_select(rsel), .adc_done(adc_done), .adc_sample(adc_sample),
		.adc_convert(adc_convert), .busy(busy), .result_valid(result_valid),
		.pga_range_wide(pga_range_wide), .internal_ref_enable(internal_ref_enable),
		.reference_io_pin_oe(reference_io_pin_oe), .ref_buffer_enable(ref_buffer_enable));
	osf_conv_model i_osf_conv_model (.pclk(pclk), .presetn(presetn), .adc_convert(adc_convert),
		.lag(lag), .adc_done(adc_done), .adc_sample(adc_sample));
	// compare and report
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: got %h want %h", $time, seen, exp);
		end
	endtask : chk
	// one apb transfer, answer taken at the pready edge
	task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		int g;
		@(posedge pclk);
		apb <= '{1'b1, 1'b0, w, a, d};
		@(posedge pclk);
		apb.penable <= 1'b1;
		g = 0;
		do begin
			@(posedge pclk);
			g++;
		end while (pready !== 1'b1 && g < 50);
		if (pready !== 1'b1) n_mismatch++;
		rd = prdata;
		er = pslverr;
		apb.psel <= 1'b0;
		apb.penable <= 1'b0;
	endtask : xfer
	// convert-start pulse on both groups, then settle
	task kick;
		@(posedge pclk);
		cst_a <= 1'b1;
		cst_b <= 1'b1;
		repeat (4) @(posedge pclk);
		cst_a <= 1'b0;
		cst_b <= 1'b0;
		repeat (20) @(posedge pclk);
	endtask : kick
	task end_of_test;
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : end_of_test
	// watchdog
	initial begin
		repeat (40000) @(posedge pclk);
		n_mismatch++;
		end_of_test;
	end
	// main sequence
	initial begin
		int n, c0, g;
		repeat (3) @(posedge pclk);
		chk({31'h0, ref_buffer_enable}, 32'h1);
		presetn <= 1'b1;
		xfer(1'b0, 12'h000, 32'h0);
		chk(rd, 32'h1);
		for (int r = 0; r < 2; r++) begin
			rng <= r[0];
			rsel <= ~r[0];
			repeat (6) @(posedge pclk);
			@(negedge pclk);
			chk({pga_range_wide, internal_ref_enable, reference_io_pin_oe, ref_buffer_enable},
				{r[0], ~r[0], ~r[0], 1'b1});
			xfer(1'b0, 12'h004, 32'h0);
			chk({30'h0, rd[6:5]}, {30'h0, ~r[0], r[0]});
		end
		$display("pin test done");
		for (int c = 0; c < 7; c++) begin
			n = 1 << c;
			osr <= 3'(c);
			lag <= c[0] ? 4'h9 : 4'h0;
			c0 = ncv;
			kick;
			g = 0;
			while (busy !== 1'b0 && g < 3000) begin
				@(negedge pclk);
				g++;
			end
			chk({31'h0, busy}, 32'h0);
			repeat (2) @(posedge pclk);
			chk(ncv - c0, n);
			chk(nrv, c + 1);
			for (int i = 0; i < 4; i++) begin
				xfer(1'b0, 12'(16 + 4 * i), 32'h0);
				chk({16'h0, rd[15:0]}, {16'h0, 16'(16'hF000 + i * 256 + 3 * k0 + 3 * (n - 1) / 2)});
			end
			k0 += n;
			xfer(1'b0, 12'h008, 32'h0);
			chk({16'h0, rd[15:0]}, 32'(c + 1));
			xfer(1'b0, 12'h004, 32'h0);
			chk({24'h0, rd[7:0] & 8'h9F}, {27'h0, 3'(c), 2'b00});
			$display("burst test %0d done", c);
		end
		osr <= 3'h7;
		c0 = ncv;
		kick;
		xfer(1'b0, 12'h004, 32'h0);
		chk({30'h0, rd[1:0]}, 32'h2);
		osr <= 3'h1;
		xfer(1'b1, 12'h000, 32'h0);
		kick;
		chk(ncv, c0);
		chk(nrv, 32'h7);
		xfer(1'b1, 12'h000, 32'h1);
		xfer(1'b1, 12'h008, 32'hFFFF);
		xfer(1'b0, 12'h008, 32'h0);
		chk({16'h0, rd[15:0]}, 32'h7);
		xfer(1'b0, 12'h020, 32'h0);
		chk({er, rd[30:0]}, 32'h80000000);
		$display("refusal test done");
		end_of_test;
	end
endmodule : osf_filter_tb_top
